// >>> include/lcts_params.svh
// Purpose: Constants of the local clock and test scheduler.
// Assumes: One 100 MHz clock; year counted from 2000.
// Notes:   Numbers only; the package holds the types.
`ifndef LCTS_PARAMS_SVH
`define LCTS_PARAMS_SVH

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define LCTS_CLK_NS      10
`define LCTS_SEC_NS      1000000000
`define LCTS_SEC_CYCLES  (`LCTS_SEC_NS / `LCTS_CLK_NS)
`define LCTS_NTP_MIN     5
`define LCTS_NTP_SECS    (`LCTS_NTP_MIN * 60)
`define LCTS_CHANGE_SEC  17'h0003C

// ------------------------------------------------------------
// Offsets and limits
// ------------------------------------------------------------
`define LCTS_QTR_MIN     12'sh00F
`define LCTS_DST_MAX     6'h30
`define LCTS_TZ_LO       8'shD1
`define LCTS_TZ_HI       8'sh30
`define LCTS_MODE_OFF    2'h0
`define LCTS_MODE_ON     2'h1
`define LCTS_MODE_AUTO   2'h2

// ------------------------------------------------------------
// Seasonal switch points
// ------------------------------------------------------------
`define LCTS_MARCH       4'h3
`define LCTS_OCTOBER     4'hA
`define LCTS_LAST_WEEK   6'h19
`define LCTS_SWITCH_HOUR 5'h01

// ------------------------------------------------------------
// Reset value: 2000-01-01 00:00:00, a Saturday
// ------------------------------------------------------------
`define LCTS_RST_TIME    {7'h00, 4'h1, 5'h01, 3'h6, 5'h00, 6'h00, 6'h00}

`endif

// >>> include/lcts_pkg.sv
// Purpose: Types and calendar arithmetic of the local clock.
// Assumes: Years 2000 to 2099, so every fourth year is a leap year.
// Notes:   Weekday 0 is Sunday.
`include "lcts_params.svh"

package lcts_pkg;

   typedef struct packed {
      logic [6:0] year;
      logic [3:0] month;
      logic [4:0] day;
      logic [2:0] wday;
      logic [4:0] hour;
      logic [5:0] min;
      logic [5:0] sec;
   } lcts_time_s;

   typedef enum logic [2:0] {
      OP_NONE   = 3'b000,
      OP_SEC    = 3'b001,
      OP_MIN_UP = 3'b010,
      OP_MIN_DN = 3'b011,
      OP_LOAD   = 3'b100
   } lcts_op_e;

   typedef enum logic [0:0] {
      ST_IDLE  = 1'b0,
      ST_ALIGN = 1'b1
   } lcts_state_e;

   function automatic logic [4:0] lcts_month_len(input logic [6:0] y, input logic [3:0] m);
      case (m)
         4'h2:                      lcts_month_len = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
         4'h4, 4'h6, 4'h9, 4'hB:    lcts_month_len = 5'h1E;
         default:                   lcts_month_len = 5'h1F;
      endcase
   endfunction

   function automatic lcts_time_s lcts_day_up(input lcts_time_s t);
      lcts_time_s r;
      r = t;
      r.wday = (t.wday == 3'h6) ? 3'h0 : t.wday + 3'h1;
      if (t.day == lcts_month_len(t.year, t.month))
      begin
         r.day = 5'h01;
         r.month = (t.month == 4'hC) ? 4'h1 : t.month + 4'h1;
         if (t.month == 4'hC)
            r.year = t.year + 7'h01;
      end
      else
         r.day = t.day + 5'h01;
      return r;
   endfunction

   function automatic lcts_time_s lcts_day_dn(input lcts_time_s t);
      lcts_time_s r;
      r = t;
      r.wday = (t.wday == 3'h0) ? 3'h6 : t.wday - 3'h1;
      if (t.day == 5'h01)
      begin
         r.month = (t.month == 4'h1) ? 4'hC : t.month - 4'h1;
         if (t.month == 4'h1)
            r.year = t.year - 7'h01;
         r.day = lcts_month_len(r.year, r.month);
      end
      else
         r.day = t.day - 5'h01;
      return r;
   endfunction

   function automatic lcts_time_s lcts_min_up(input lcts_time_s t);
      lcts_time_s r;
      r = t;
      r.min = (t.min == 6'h3B) ? 6'h00 : t.min + 6'h01;
      if (t.min == 6'h3B)
      begin
         r.hour = (t.hour == 5'h17) ? 5'h00 : t.hour + 5'h01;
         if (t.hour == 5'h17)
            r = lcts_day_up(r);
      end
      return r;
   endfunction

   function automatic lcts_time_s lcts_min_dn(input lcts_time_s t);
      lcts_time_s r;
      r = t;
      r.min = (t.min == 6'h00) ? 6'h3B : t.min - 6'h01;
      if (t.min == 6'h00)
      begin
         r.hour = (t.hour == 5'h00) ? 5'h17 : t.hour - 5'h01;
         if (t.hour == 5'h00)
            r = lcts_day_dn(r);
      end
      return r;
   endfunction

   function automatic logic [16:0] lcts_sod(input lcts_time_s t);
      return 17'(t.hour) * 17'h00E10 + 17'(t.min) * 17'h0003C + 17'(t.sec);
   endfunction

   // Summer season by date alone; callers use it as is at load, so the whole switch day counts as after the switch.
   function automatic logic lcts_season(input lcts_time_s t);
      logic late;
      late = 6'(t.day) >= 6'(t.wday) + `LCTS_LAST_WEEK;
      if (t.month == `LCTS_MARCH)
         return late;
      else if (t.month == `LCTS_OCTOBER)
         return !late;
      else
         return (t.month > `LCTS_MARCH) && (t.month < `LCTS_OCTOBER);
   endfunction

endpackage

// >>> include/lcts_cal_if.sv
// Purpose: Carrier between the scheduler and its calendar counter.
// Assumes: One operation per clock cycle.
// Notes:   The calendar holds the local time.
`timescale 1ns/1ps

interface lcts_cal_if;
   import lcts_pkg::*;
   lcts_op_e   op;
   lcts_time_s ld;
   lcts_time_s now;
   modport ctrl (output op, output ld, input now);
   modport cal  (input op, input ld, output now);
endinterface

// >>> logic/lcts_calendar.sv
// Purpose: Calendar counter stepped by second, by minute up or down, or loaded.
// Assumes: Operations arrive from logic on the same clock.
// Notes:   Month lengths and leap years come from the package functions.
`timescale 1ns/1ps
`include "lcts_params.svh"

module lcts_calendar
(
   input wire logic clk_i,    // System clock.
   input wire logic rst_b_i,  // Asynchronous reset, active low.
   lcts_cal_if.cal  cal       // Operation in, time out.
);
   import lcts_pkg::*;

   lcts_time_s t;
   lcts_time_s next_t;

   always_comb
   begin
      next_t = t;
      case (cal.op)
         OP_LOAD:   next_t = cal.ld;
         OP_SEC:
         begin
            next_t.sec = (t.sec == 6'h3B) ? 6'h00 : t.sec + 6'h01;
            if (t.sec == 6'h3B)
               next_t = lcts_min_up(next_t);
         end
         OP_MIN_UP: next_t = lcts_min_up(t);
         OP_MIN_DN: next_t = lcts_min_dn(t);
         default:   next_t = t;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         t <= `LCTS_RST_TIME;
      else
         t <= next_t;
   end

   assign cal.now = t;

   a_load_time: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      cal.op == OP_LOAD |=> t == $past(cal.ld))
      else $error("Calendar did not take the loaded time.");

   a_sec_step: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (cal.op == OP_SEC && t.sec != 6'h3B) |=> t.sec == $past(t.sec) + 6'h01
                                               && t.min == $past(t.min))
      else $error("Second did not advance by one.");

   a_sec_wrap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (cal.op == OP_SEC && t.sec == 6'h3B && t.min != 6'h3B)
         |=> t.sec == 6'h00 && t.min == $past(t.min) + 6'h01)
      else $error("Minute did not advance on second wrap.");

endmodule

// >>> logic/lcts_top.sv
// Purpose: Local clock corrected from network time, with a weekly test scheduler.
// Assumes: Config, time and command inputs come from logic on MCLK_I; NET_LINK_I is a pin.
// Notes:   The calendar holds local time; the applied offset tracks zone plus summer time.
`timescale 1ns/1ps
`include "lcts_params.svh"

module lcts_top
#(
   parameter int unsigned SEC_CYCLES = `LCTS_SEC_CYCLES   // Clock cycles per second.
)
(
   input  wire logic              MCLK_I,          // System clock, 100 MHz.
   input  wire logic              RST_B_I,         // Asynchronous reset, active low.
   input  wire logic              NET_LINK_I,      // Network connection present.
   input  wire logic              UTC_VALID_I,     // Pulse: UTC_TIME_I holds server time.
   input  wire lcts_pkg::lcts_time_s UTC_TIME_I,   // Universal time from the server.
   input  wire logic              SET_VALID_I,     // Pulse: operator writes local time.
   input  wire lcts_pkg::lcts_time_s SET_TIME_I,   // Local time from menu or serial port.
   input  wire logic [5:0]        DST_OFS_I,       // Summer offset, quarter hours.
   input  wire logic [1:0]        DST_MODE_I,      // Summer mode: off, on, automatic.
   input  wire logic signed [7:0] TZ_I,            // Zone offset, signed quarter hours.
   input  wire logic [6:0]        TEST_DAYS_I,     // Test day mask, bit 0 Sunday.
   input  wire logic [4:0]        TEST_HOUR_I,     // Test start hour.
   input  wire logic [5:0]        TEST_MIN_I,      // Test start minute.
   input  wire logic [7:0]        TEST_DUR_I,      // Test length in minutes.
   input  wire logic              SMS_TEST_I,      // Pulse: remote test command.
   output      logic              NTP_REQ_O,       // Pulse: request time from server.
   output      lcts_pkg::lcts_time_s TIME_O,       // Running local time.
   output      logic              TIME_CHANGED_O,  // Pulse: time changed event.
   output      logic              TEST_ACTIVE_O,   // Test run in progress.
   output      logic              DST_ACTIVE_O     // Summer offset in force.
);
   import lcts_pkg::*;

   lcts_cal_if cal ();

   logic [31:0]        pre_cnt, next_pre_cnt;
   logic               tick, next_tick, tick_d;
   logic               link_m, link_s;
   logic [8:0]         ntp_cnt, next_ntp_cnt;
   logic               ntp_req, next_ntp_req;
   logic [5:0]         dst_ofs, next_dst_ofs;
   logic [1:0]         dst_mode, next_dst_mode;
   logic signed [7:0]  tz, next_tz;
   logic [6:0]         days, next_days;
   logic [4:0]         t_hour, next_t_hour;
   logic [5:0]         t_min, next_t_min;
   logic [7:0]         dur, next_dur;
   logic               dst_auto, next_dst_auto;
   logic               dst_on, next_dst_on;
   logic signed [11:0] applied, next_applied;
   logic signed [11:0] desired;
   lcts_state_e        st, next_st;
   lcts_time_s         old, next_old;
   logic               chg, next_chg;
   logic               test_on, next_test_on;
   logic [7:0]         left, next_left;
   logic [16:0]        sod_a, sod_b;

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb
   begin
      next_pre_cnt  = (pre_cnt == SEC_CYCLES - 1) ? 32'h00000000 : pre_cnt + 32'h00000001;
      next_tick     = (pre_cnt == SEC_CYCLES - 1);
      next_ntp_cnt  = ntp_cnt;
      next_ntp_req  = 1'b0;
      next_dst_ofs  = dst_ofs;
      next_dst_mode = dst_mode;
      next_tz       = tz;
      next_days     = TEST_DAYS_I;
      next_t_hour   = TEST_HOUR_I;
      next_t_min    = TEST_MIN_I;
      next_dur      = TEST_DUR_I;
      next_dst_auto = dst_auto;
      next_applied  = applied;
      next_st       = st;
      next_old      = old;
      next_chg      = 1'b0;
      next_test_on  = test_on;
      next_left     = left;
      cal.op        = OP_NONE;
      cal.ld        = UTC_TIME_I;
      sod_a         = lcts_sod(old);
      sod_b         = lcts_sod(cal.now);

      // Out-of-range summer and zone settings are refused and the last good value kept.
      if (DST_OFS_I <= `LCTS_DST_MAX)
         next_dst_ofs = DST_OFS_I;
      if (DST_MODE_I <= `LCTS_MODE_AUTO)
         next_dst_mode = DST_MODE_I;
      if (TZ_I >= `LCTS_TZ_LO && TZ_I <= `LCTS_TZ_HI)
         next_tz = TZ_I;

      if (!link_s)
         next_ntp_cnt = 9'h000;
      else if (tick && ntp_cnt == 9'(`LCTS_NTP_SECS - 1))
      begin
         next_ntp_cnt = 9'h000;
         next_ntp_req = 1'b1;
      end
      else if (tick)
         next_ntp_cnt = ntp_cnt + 9'h001;

      // Automatic summer time switches as 01.00 begins on the last Sunday.
      if (tick_d && cal.now.hour == `LCTS_SWITCH_HOUR && cal.now.min == 6'h00
          && cal.now.sec == 6'h00 && cal.now.wday == 3'h0
          && 6'(cal.now.day) >= `LCTS_LAST_WEEK)
      begin
         if (cal.now.month == `LCTS_MARCH)
            next_dst_auto = 1'b1;
         else if (cal.now.month == `LCTS_OCTOBER)
            next_dst_auto = 1'b0;
      end

      // Server time is loaded raw, then walked a minute per cycle to local.
      if (UTC_VALID_I)
      begin
         cal.op        = OP_LOAD;
         next_applied  = 12'sh000;
         next_old      = cal.now;
         next_st       = ST_ALIGN;
         next_dst_auto = lcts_season(UTC_TIME_I);
      end
      else if (SET_VALID_I)
      begin
         cal.op        = OP_LOAD;
         cal.ld        = SET_TIME_I;
         next_dst_auto = lcts_season(SET_TIME_I);
      end
      else if (tick)
         cal.op = OP_SEC;
      else if (applied < desired)
      begin
         cal.op       = OP_MIN_UP;
         next_applied = applied + 12'sh001;
      end
      else if (applied > desired)
      begin
         cal.op       = OP_MIN_DN;
         next_applied = applied - 12'sh001;
      end
      else if (st == ST_ALIGN)
      begin
         next_st  = ST_IDLE;
         next_chg = ({old.year, old.month, old.day} != {cal.now.year, cal.now.month, cal.now.day})
                 || ((sod_a > sod_b) ? sod_a - sod_b : sod_b - sod_a) > `LCTS_CHANGE_SEC;
      end

      // Scheduled start at a minute boundary; remote start loads the same count and ends at the dur-th minute boundary after it.
      if (SMS_TEST_I && dur != 8'h00)
      begin
         next_test_on = 1'b1;
         next_left    = dur;
      end
      else if (tick_d && cal.now.sec == 6'h00)
      begin
         if (!test_on && days[cal.now.wday] && dur != 8'h00
             && cal.now.hour == t_hour && cal.now.min == t_min)
         begin
            next_test_on = 1'b1;
            next_left    = dur;
         end
         else if (test_on)
         begin
            next_left = left - 8'h01;
            if (left == 8'h01)
               next_test_on = 1'b0;
         end
      end

      next_dst_on = (dst_mode == `LCTS_MODE_ON)
                 || (dst_mode == `LCTS_MODE_AUTO && dst_auto);
   end

   // Target offset in minutes: zone plus summer time when in force.
   assign desired = 12'({{4{tz[7]}}, tz}) * `LCTS_QTR_MIN
                  + (dst_on ? $signed({6'h00, dst_ofs}) * `LCTS_QTR_MIN : 12'sh000);

   // ------------------------------------------------------------
   // State registers
   // ------------------------------------------------------------
   always_ff @(posedge MCLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         pre_cnt  <= 32'h00000000;
         tick     <= 1'b0;
         tick_d   <= 1'b0;
         ntp_cnt  <= 9'h000;
         ntp_req  <= 1'b0;
         dst_ofs  <= 6'h00;
         dst_mode <= `LCTS_MODE_OFF;
         tz       <= 8'sh00;
         days     <= 7'h00;
         t_hour   <= 5'h00;
         t_min    <= 6'h00;
         dur      <= 8'h00;
         dst_auto <= 1'b0;
         dst_on   <= 1'b0;
         applied  <= 12'sh000;
         st       <= ST_IDLE;
         old      <= `LCTS_RST_TIME;
         chg      <= 1'b0;
         test_on  <= 1'b0;
         left     <= 8'h00;
         link_m   <= 1'b0;
         link_s   <= 1'b0;
      end
      else
      begin
         pre_cnt  <= next_pre_cnt;
         tick     <= next_tick;
         tick_d   <= tick;
         ntp_cnt  <= next_ntp_cnt;
         ntp_req  <= next_ntp_req;
         dst_ofs  <= next_dst_ofs;
         dst_mode <= next_dst_mode;
         tz       <= next_tz;
         days     <= next_days;
         t_hour   <= next_t_hour;
         t_min    <= next_t_min;
         dur      <= next_dur;
         dst_auto <= next_dst_auto;
         dst_on   <= next_dst_on;
         applied  <= next_applied;
         st       <= next_st;
         old      <= next_old;
         chg      <= next_chg;
         test_on  <= next_test_on;
         left     <= next_left;
         link_m   <= NET_LINK_I;
         link_s   <= link_m;
      end
   end

   lcts_calendar u_cal
   (
      .clk_i   (MCLK_I),
      .rst_b_i (RST_B_I),
      .cal     (cal.cal)
   );

   assign NTP_REQ_O      = ntp_req;
   assign TIME_O         = cal.now;
   assign TIME_CHANGED_O = chg;
   assign TEST_ACTIVE_O  = test_on;
   assign DST_ACTIVE_O   = dst_on;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RST_B_I);
   a_event_after_align: assert property ($rose(chg) |-> $past(st) == ST_ALIGN
                                         && st == ST_IDLE)
      else $error("Time change logged outside alignment.");
   a_ntp_needs_link: assert property (ntp_req |-> $past(link_s) && $past(tick))
      else $error("Time request without link or second tick.");
   a_utc_raw_load: assert property (UTC_VALID_I |=> applied == 12'sh000 && st == ST_ALIGN)
      else $error("Server time not loaded as universal time.");
   a_dst_range: assert property (dst_ofs <= `LCTS_DST_MAX)
      else $error("Summer offset out of range.");
   a_mode_off: assert property (dst_mode == `LCTS_MODE_OFF |=> !dst_on)
      else $error("Summer offset applied in mode 0.");
   a_mode_auto: assert property (dst_mode == `LCTS_MODE_AUTO |=> dst_on == $past(dst_auto))
      else $error("Automatic summer state not followed.");
   a_tz_range: assert property (tz >= `LCTS_TZ_LO && tz <= `LCTS_TZ_HI)
      else $error("Zone offset out of range.");
   a_test_day: assert property ($rose(test_on) && !$past(SMS_TEST_I)
                                |-> $past(days[cal.now.wday] && tick_d))
      else $error("Test started on a disabled day.");
   a_test_start: assert property ($rose(test_on) && !$past(SMS_TEST_I)
                                  |-> $past(cal.now.hour == t_hour && cal.now.min == t_min))
      else $error("Test started at the wrong time.");
   a_test_len: assert property ($fell(test_on) |-> $past(left) == 8'h01 && left == 8'h00)
      else $error("Test ended before its duration.");

endmodule

// >>> bench/lcts_srv_model.sv
// Purpose: Time server model that answers each request with one UTC sample.
// Assumes: Requests are one-cycle pulses on the system clock.
// Notes:   Data lines change every cycle outside the answer cycle.
`timescale 1ns/1ps

module lcts_srv_model
#(
   parameter int DLY = 3                  // Answer delay in cycles.
)
(
   input  wire logic                 clk_i,    // System clock.
   input  wire logic                 rst_b_i,  // Reset, active low.
   input  wire logic                 req_i,    // Request pulse.
   input  wire lcts_pkg::lcts_time_s utc_i,    // Time to serve.
   output logic                      valid_o,  // Answer pulse.
   output lcts_pkg::lcts_time_s      time_o,   // Served time.
   output int                        n_req_o   // Requests seen.
);
   import lcts_pkg::*;
   int cnt;

   always @(posedge clk_i or negedge rst_b_i)
      if (!rst_b_i)
      begin
         cnt <= 0;
         valid_o <= 1'b0;
         time_o <= '0;
         n_req_o <= 0;
      end
      else
      begin
         valid_o <= 1'b0;
         time_o <= ~time_o;
         if (req_i === 1'b1)
         begin
            n_req_o <= n_req_o + 1;
            cnt <= DLY;
         end
         else if (cnt == 1)
         begin
            valid_o <= 1'b1;
            time_o <= utc_i;
            cnt <= 0;
         end
         else if (cnt > 1)
            cnt <= cnt - 1;
      end
endmodule

// >>> bench/tb.sv
// Purpose: Self-checking bench of the local clock and test scheduler.
// Assumes: SEC_CYCLES is 20, so one second lasts 20 clock cycles.
// Notes:   A time server model answers the clock's requests.
`timescale 1ns/1ps
`include "lcts_params.svh"

module tb;
   import lcts_pkg::*;
   logic              clk, rst_b, link, set_v, sms, req, chg, act, dst, uv;
   logic [5:0]        ofs, tm;
   logic [1:0]        mode;
   logic signed [7:0] tz;
   logic [6:0]        days;
   logic [4:0]        th;
   logic [7:0]        dur;
   lcts_time_s        set_t, tim, ut, srv_t;
   int                n_fail, num_checks, n_evt, n_req;

   lcts_top #(.SEC_CYCLES(20)) DUT (.MCLK_I(clk), .RST_B_I(rst_b), .NET_LINK_I(link),
      .UTC_VALID_I(uv), .UTC_TIME_I(ut), .SET_VALID_I(set_v), .SET_TIME_I(set_t),
      .DST_OFS_I(ofs), .DST_MODE_I(mode), .TZ_I(tz), .TEST_DAYS_I(days), .TEST_HOUR_I(th),
      .TEST_MIN_I(tm), .TEST_DUR_I(dur), .SMS_TEST_I(sms), .NTP_REQ_O(req), .TIME_O(tim),
      .TIME_CHANGED_O(chg), .TEST_ACTIVE_O(act), .DST_ACTIVE_O(dst));
   lcts_srv_model #(.DLY(3)) SRV (.clk_i(clk), .rst_b_i(rst_b), .req_i(req),
      .utc_i(srv_t), .valid_o(uv), .time_o(ut), .n_req_o(n_req));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk)
      if (chg === 1'b1)
         n_evt++;

   function automatic lcts_time_s mk(int mo, d, w, h, mi, s);
      return '{7'h00, 4'(mo), 5'(d), 3'(w), 5'(h), 6'(mi), 6'(s)};
   endfunction

   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(string nm, logic [36:0] g, logic [36:0] e);
      num_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic ld(lcts_time_s t);
      set_t = t;
      set_v = 1'b1;
      cyc(1);
      set_v = 1'b0;
      cyc(1);
   endtask

   // Waits for the test flag to reach v; e says whether it should.
   task automatic w_act(logic v, int n, logic e);
      for (int i = 0; i < n && act !== v; i++)
         cyc(1);
      chk("test flag wait", act === v, e);
      if ((act === v) !== e)
         test_done;
   endtask

   task automatic w_req(int k, int n);
      for (int i = 0; i < n && n_req < k; i++)
         cyc(1);
      chk("request count", n_req, k);
      if (n_req != k)
         test_done;
   endtask

   task automatic t_reset;
      chk("reset time", tim, `LCTS_RST_TIME);
      chk("reset outputs", {req, chg, act, dst}, 4'h0);
   endtask

   task automatic t_cal;
      ld(mk(2, 28, 1, 23, 59, 59));
      for (int i = 0; i < 25 && tim.sec === 6'h3B; i++)
         cyc(1);
      chk("leap day", tim, mk(2, 29, 2, 0, 0, 0));
   endtask

   task automatic t_sched;
      dur = 8'h02;
      th = 5'h0A;
      tm = 6'h00;
      days = 7'h02;
      ld(mk(1, 3, 1, 9, 59, 59));
      w_act(1'b1, 40, 1'b1);
      cyc(2370);
      chk("test running", act, 1'b1);
      cyc(60);
      chk("test ended", act, 1'b0);
      days = 7'h7D;
      ld(mk(1, 3, 1, 9, 59, 59));
      w_act(1'b1, 40, 1'b0);
      days = 7'h40;
      ld(mk(1, 1, 6, 9, 59, 59));
      w_act(1'b1, 40, 1'b1);
      w_act(1'b0, 2600, 1'b1);
      days = 7'h01;
      ld(mk(1, 2, 0, 9, 59, 59));
      w_act(1'b1, 40, 1'b1);
      w_act(1'b0, 2600, 1'b1);
   endtask

   task automatic t_sms;
      days = 7'h00;
      dur = 8'h01;
      ld(mk(1, 4, 2, 12, 0, 30));
      sms = 1'b1;
      cyc(1);
      sms = 1'b0;
      cyc(1);
      chk("remote start", act, 1'b1);
      cyc(500);
      chk("remote running", act, 1'b1);
      w_act(1'b0, 200, 1'b1);
   endtask

   task automatic t_dst;
      lcts_time_s q[5];
      logic [4:0] ex;
      q = '{mk(3, 25, 6, 12, 0, 0), mk(3, 26, 0, 12, 0, 0), mk(7, 10, 1, 12, 0, 0),
            mk(10, 28, 6, 12, 0, 0), mk(10, 29, 0, 12, 0, 0)};
      ex = 5'h0E;
      mode = 2'h2;
      ofs = 6'h04;
      foreach (q[i])
      begin
         ld(q[i]);
         cyc(4);
         chk("summer flag", dst, ex[i]);
      end
      ld(q[2]);
      mode = 2'h0;
      cyc(4);
      chk("summer off", dst, 1'b0);
   endtask

   task automatic t_ntp;
      int e0;
      mode = 2'h1;
      ofs = 6'h04;
      tz = 8'sh04;
      cyc(3);
      chk("summer always", dst, 1'b1);
      ofs = 6'h31;
      tz = 8'shD0;
      srv_t = mk(6, 15, 4, 10, 0, 0);
      e0 = n_evt;
      link = 1'b1;
      cyc(5900);
      chk("early request", n_req, 0);
      w_req(1, 300);
      cyc(200);
      chk("local hour", tim.hour, 5'h0C);
      chk("local date", {tim.day, tim.min}, {5'h0F, 6'h00});
      chk("change logged", n_evt - e0, 1);
      srv_t = mk(6, 15, 4, 10, 5, 30);
      w_req(2, 6300);
      cyc(200);
      chk("small change", n_evt - e0, 1);
      chk("local minute", tim.min, 6'h05);
   endtask

   initial
   begin
      rst_b = 1'b0;
      {link, set_v, sms, mode, days, th, tm, dur} = '0;
      {set_t, srv_t, ofs, tz} = '0;
      n_fail = 0;
      num_checks = 0;
      cyc(5);
      t_reset;
      rst_b = 1'b1;
      cyc(2);
      t_cal;
      t_sched;
      t_sms;
      t_dst;
      t_ntp;
      test_done;
   end
endmodule
